/* File: common/ifdc_map.svh */
// Offsets, field positions, reset values and defaults of the IF divider words
// Summary of operation
// - A serial word whose low four bits are 0111 and whose top seven bits are 0001000 loads the N counter.
// - Loaded N, R and test words apply only while default selection is zero.
// - The N divider is a 9-bit program count with a 4-bit swallow count.
// - Ratio is sixteen times program plus swallow; swallow stays below program, though any loaded pair is applied unchecked.
// - N word holds 0001000, then swallow, then program, then the address.
// - A serial word whose low five bits are 01111 and whose top ten bits are 0011000010 loads the R divider.
// - A serial word whose low six bits are 011111 loads the test word.
`ifndef IFDC_MAP_SVH
`define IFDC_MAP_SVH

`define IFDC_WORD_W        24

`define IFDC_N_ADDR        4'h7
`define IFDC_R_ADDR        5'h0f
`define IFDC_T_ADDR        6'h1f
`define IFDC_BASE_ADDR     2'h0

`define IFDC_N_FIXED       7'h08
`define IFDC_R_FIXED       10'h0c2
`define IFDC_T_VALUE       18'h20000

`define IFDC_N_FIXED_HI    23
`define IFDC_N_FIXED_LO    17
`define IFDC_A_HI          16
`define IFDC_A_LO          13
`define IFDC_B_HI          12
`define IFDC_B_LO          4
`define IFDC_R_FIXED_HI    23
`define IFDC_R_FIXED_LO    14
`define IFDC_R_HI          13
`define IFDC_R_LO          5
`define IFDC_T_HI          23
`define IFDC_T_LO          6

`define IFDC_DEF_SEL_BIT   2
`define IFDC_DEF_SEL_RST   1'h1

`define IFDC_DEF_A         4'h0
`define IFDC_DEF_B         9'h040
`define IFDC_DEF_R         9'h002

`endif

/* File: common/ifdc_pkg.sv */
// Types shared by the IF divider configuration block
package ifdc_pkg;

  typedef struct packed
  {
    logic [23:0] shift;
  } ifdc_link_t;

  typedef struct packed
  {
    logic [2:0]  le_sync;
    logic        def_sel;
    logic [3:0]  a_word;
    logic [8:0]  b_word;
    logic [8:0]  r_word;
    logic        test_word;
    logic [3:0]  applied_a;
    logic [8:0]  applied_b;
    logic [8:0]  applied_r;
    logic [12:0] applied_ratio;
    logic        test_active;
    logic        defaults_used;
  } ifdc_state_t;

endpackage

/* File: rtl/ifdc_config.sv */
// IF divider configuration words: serial capture, decode and apply
`timescale 1ns/1ps
`include "ifdc_map.svh"

module ifdc_config
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ser_clk,
  input  wire logic        ser_data,
  input  wire logic        ser_le,
  output logic [3:0]       if_a_count,
  output logic [8:0]       if_b_count,
  output logic [8:0]       if_r_count,
  output logic [12:0]      if_n_ratio,
  output logic             test_mode_active,
  output logic             defaults_in_use
);

  ////////////////////////////////////////////////////////////////////////////
  // Link side

  logic [23:0] shift_word;

  ifdc_shift u_shift
  (
    .ser_clk    (ser_clk),
    .rstn       (rstn),
    .ser_data   (ser_data),
    .shift_word (shift_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // System side

  ifdc_pkg::ifdc_state_t st;
  ifdc_pkg::ifdc_state_t next_st;

  logic        latch_edge;
  logic [23:0] word;
  logic        n_hit;
  logic        r_hit;
  logic        t_hit;
  logic        base_hit;

  // The link clock is stopped while the latch pin is high, so the shift
  // word is static when the synchronised rising edge samples it
  assign latch_edge = st.le_sync[1] & ~st.le_sync[2];
  assign word       = shift_word;

  // Four-bit pattern tested first, then five, then six
  always_comb
  begin
    n_hit    = 1'b0;
    r_hit    = 1'b0;
    t_hit    = 1'b0;
    base_hit = 1'b0;
    if (word[3:0] == `IFDC_N_ADDR)
    begin
      n_hit = word[`IFDC_N_FIXED_HI:`IFDC_N_FIXED_LO] == `IFDC_N_FIXED;
    end
    else if (word[4:0] == `IFDC_R_ADDR)
    begin
      r_hit = word[`IFDC_R_FIXED_HI:`IFDC_R_FIXED_LO] == `IFDC_R_FIXED;
    end
    else if (word[5:0] == `IFDC_T_ADDR)
    begin
      t_hit = 1'b1;
    end
    else if (word[1:0] == `IFDC_BASE_ADDR)
    begin
      base_hit = 1'b1;
    end
  end

  always_comb
  begin
    next_st = st;
    next_st.le_sync = {st.le_sync[1:0], ser_le};
    if (latch_edge)
    begin
      if (n_hit)
      begin
        next_st.a_word = word[`IFDC_A_HI:`IFDC_A_LO];
        next_st.b_word = word[`IFDC_B_HI:`IFDC_B_LO];
      end
      if (r_hit)
      begin
        next_st.r_word = word[`IFDC_R_HI:`IFDC_R_LO];
      end
      if (t_hit)
      begin
        next_st.test_word = word[`IFDC_T_HI:`IFDC_T_LO] == `IFDC_T_VALUE;
      end
      if (base_hit)
      begin
        next_st.def_sel = word[`IFDC_DEF_SEL_BIT];
      end
    end
    // Built-in values stand in while default selection is set
    if (next_st.def_sel)
    begin
      next_st.applied_a   = `IFDC_DEF_A;
      next_st.applied_b   = `IFDC_DEF_B;
      next_st.applied_r   = `IFDC_DEF_R;
      next_st.test_active = 1'b0;
    end
    else
    begin
      next_st.applied_a   = next_st.a_word;
      next_st.applied_b   = next_st.b_word;
      next_st.applied_r   = next_st.r_word;
      next_st.test_active = next_st.test_word;
    end
    // Sixteen times program count plus swallow is a plain concatenation
    next_st.applied_ratio = {next_st.applied_b, next_st.applied_a};
    next_st.defaults_used = next_st.def_sel;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st               <= '0;
      st.def_sel       <= `IFDC_DEF_SEL_RST;
      st.a_word        <= `IFDC_DEF_A;
      st.b_word        <= `IFDC_DEF_B;
      st.r_word        <= `IFDC_DEF_R;
      st.applied_a     <= `IFDC_DEF_A;
      st.applied_b     <= `IFDC_DEF_B;
      st.applied_r     <= `IFDC_DEF_R;
      st.applied_ratio <= {`IFDC_DEF_B, `IFDC_DEF_A};
      st.defaults_used <= `IFDC_DEF_SEL_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign if_a_count       = st.applied_a;
  assign if_b_count       = st.applied_b;
  assign if_r_count       = st.applied_r;
  assign if_n_ratio       = st.applied_ratio;
  assign test_mode_active = st.test_active;
  assign defaults_in_use  = st.defaults_used;

endmodule

/* File: rtl/ifdc_shift.sv */
// Serial shift register clocked by the three-wire link clock
`timescale 1ns/1ps
`include "ifdc_map.svh"

module ifdc_shift
(
  input  wire logic        ser_clk,
  input  wire logic        rstn,
  input  wire logic        ser_data,
  output logic [23:0]      shift_word
);

  ifdc_pkg::ifdc_link_t st;
  ifdc_pkg::ifdc_link_t next_st;

  // MSB first; the newest bit lands in bit 0, so the address ends up lowest
  always_comb
  begin
    next_st = st;
    next_st.shift = {st.shift[`IFDC_WORD_W-2:0], ser_data};
  end

  always_ff @(posedge ser_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign shift_word = st.shift;

endmodule

/* File: test/ifdc_host.sv */
// Host model driving the three-wire serial link
`timescale 1ns/1ps
module ifdc_host
(
  output logic ser_clk = 1'b0,
  output logic ser_data = 1'b0,
  output logic ser_le = 1'b0
);
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--)
    begin
      ser_data = w[i];
      #12 ser_clk = 1'b1;
      #24 ser_clk = 1'b0;
      #12;
    end
    ser_data = ~ser_data;
    #7 ser_le = 1'b1;
    #40 ser_le = 1'b0;
    #40;
  endtask
endmodule

/* File: test/ifdc_properties.sv */
// Checks at the ports of the IF divider configuration block
`timescale 1ns/1ps
module ifdc_props
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        ser_clk,
  input wire logic        ser_data,
  input wire logic        ser_le,
  input wire logic [3:0]  if_a_count,
  input wire logic [8:0]  if_b_count,
  input wire logic [8:0]  if_r_count,
  input wire logic [12:0] if_n_ratio,
  input wire logic        test_mode_active,
  input wire logic        defaults_in_use
);
  logic [23:0] sh;
  logic [23:0] w;
  always_ff @(posedge ser_clk or negedge rstn)
    if (!rstn) sh <= 24'h0;
    else sh <= {sh[22:0], ser_data};
  always_ff @(posedge clk or negedge rstn)
    if (!rstn) w <= 24'h0;
    else if ($rose(ser_le)) w <= sh;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence got(m);
    $rose(ser_le) ##1 m && !defaults_in_use;
  endsequence
  ratio_sum_a:
    assert property (if_n_ratio == {if_b_count, if_a_count}) else $error("sum");
  dflt_shown_a:
    assert property (defaults_in_use |-> if_a_count == 4'h0 &&
      if_b_count == 9'h040 && if_r_count == 9'h002) else $error("dflt");
  test_gated_a:
    assert property (test_mode_active |-> !defaults_in_use) else $error("gate");
  n_load_a:
    assert property (got(w[3:0] == 4'h7 && w[23:17] == 7'h08)
      |-> ##4 {if_a_count, if_b_count} == w[16:4]) else $error("n");
  r_load_a:
    assert property (got(w[4:0] == 5'h0f && w[23:14] == 10'h0c2)
      |-> ##4 if_r_count == w[13:5]) else $error("r");
  t_load_a:
    assert property (got(w[5:0] == 6'h1f)
      |-> ##4 test_mode_active == (w[23:6] == 18'h20000)) else $error("t");
  base_load_a:
    assert property ($rose(ser_le) ##1 w[1:0] == 2'h0
      |-> ##4 defaults_in_use == w[2]) else $error("base");
  n_refuse_a:
    assert property (got(w[3:0] == 4'h7 && w[23:17] != 7'h08)
      |-> $stable(if_n_ratio) [*5]) else $error("refuse");
endmodule
bind ifdc_config ifdc_props chk_u (.*);

/* File: test/testbench.sv */
// Self-checking bench of the IF divider configuration block
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0, rstn = 1'b0, ser_clk, ser_data, ser_le;
  logic        nt = 1'b0, ed = 1'b1, test_mode_active, defaults_in_use;
  logic [3:0]  if_a_count, na;
  logic [8:0]  if_b_count, if_r_count, nb, nr;
  logic [12:0] if_n_ratio;
  integer      seed = 32'h6786, num_errors = 0, total_checks = 0, cyc = 0;
  always #5 clk = ~clk;
  ifdc_host host_u (.*);
  ifdc_config dut_u (.*);
  function automatic logic [36:0] expv();
    return ed ? {4'h0, 9'h040, 9'h002, 13'h400, 2'h1}
      : {na, nb, nr, nb, na, nt, 1'b0};
  endfunction
  task automatic chk(input string s);
    total_checks++;
    if ({if_a_count, if_b_count, if_r_count, if_n_ratio, test_mode_active,
      defaults_in_use} !== expv())
    begin
      num_errors++;
      $display("MISMATCH %0t %s", $time, s);
    end
    $display("test %s ended", s);
  endtask
  task automatic put(input logic [23:0] w);
    @(posedge clk);
    host_u.send(w);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 9000)
    begin
      num_errors++;
      close_out();
    end
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    put({7'h08, 4'h5, 9'h0a0, 4'h7});
    chk("n under defaults");
    put(24'h0);
    ed = 1'b0;
    for (int i = 0; i < 10; i++)
    begin
      na = 4'($random(seed));
      nb = na + 9'h001 + 9'({$random(seed)} % (511 - na));
      nr = 9'h002 + 9'({$random(seed)} % 510);
      if (i == 0) {na, nb, nr} = {4'hf, 9'h1ff, 9'h1ff};
      if (i == 1) {na, nb, nr} = {4'h0, 9'h001, 9'h002};
      put({7'h08, na, nb, 4'h7});
      put({10'h0c2, nr, 5'h0f});
      chk("random n and r");
    end
    put({7'h09, 4'h3, 9'h033, 4'h7});
    put({10'h0c3, 9'h044, 5'h0f});
    chk("bad fixed bits");
    put({18'h20000, 6'h1f});
    nt = 1'b1;
    chk("test word");
    put(24'h4);
    ed = 1'b1;
    chk("defaults back");
    put(24'h0);
    ed = 1'b0;
    chk("stored words back");
    put({18'h00001, 6'h1f});
    nt = 1'b0;
    chk("other test word");
    close_out();
  end
endmodule
